// file: logic/fpc_regs.sv
// Protect, function and read-parameter registers behind the serial pins
// Assumes array core on clk; pins and serial clock asynchronous to clk
`include "fpc_cfg.svh"
module fpc_regs (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            csN,
  input  wire logic            sck,
  input  wire logic            si,
  input  wire logic            wpN,
  input  wire logic            holdN,
  input  wire logic            opDone,
  output logic                 so,
  output logic                 soOe,
  output logic                 opStart,
  output fpc_pkg::fpc_op_s     opReq,
  output logic [7:0]           statusByte,
  output logic [7:0]           funcByte,
  output logic [7:0]           readParam,
  output logic [6:0]           burstBytes,
  output logic                 pinsAsData,
  output logic                 wpActive,
  output logic                 holdActive
);
  fpc_pkg::fpc_state_s q;
  fpc_pkg::fpc_state_s n;

  ////////////////////////////////////////////////////////////////////////
  // Protection map

  function automatic logic isProt(input logic [3:0] lvl,
                                  input logic       bot,
                                  input logic [6:0] blk);
    logic [7:0] cnt;
    cnt = 8'h01 << (lvl[2:0] - 3'h1);
    if (lvl[3]) begin
      isProt = 1'b1;
    end else if (lvl[2:0] == 3'h0) begin
      isProt = 1'b0;
    end else if (bot) begin
      isProt = {1'b0, blk} < cnt;
    end else begin
      isProt = {1'b0, blk} >= (`FPC_ALL_BLKS - cnt);
    end
  endfunction

  function automatic logic isRead(input logic [7:0] opc);
    isRead = (opc == `FPC_OP_STAT_RD) || (opc == `FPC_OP_FUNC_RD) ||
             (opc == `FPC_OP_RDP_RD);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic       sckRise;
  logic       sckFall;
  logic       csRise;
  logic       csHigh;
  logic       wpLow;
  logic [2:0] nb;
  logic [7:0] newByte;
  logic [7:0] stByte;
  logic [7:0] fnByte;
  logic [7:0] rdByte;
  logic       canWr;

  always_comb begin
    n = q;
    n.opStart = 1'b0;
    n.syn1 = {csN, sck, si, wpN, holdN};
    n.syn2 = q.syn1;
    n.sckPrev = q.syn2[3];
    n.csPrev = q.syn2[4];
    csHigh = q.syn2[4];
    sckRise = q.syn2[3] & ~q.sckPrev;
    sckFall = ~q.syn2[3] & q.sckPrev;
    csRise = csHigh & ~q.csPrev;
    wpLow = ~q.st.qe & ~q.syn2[1];
    nb = q.bitCnt[5:3];
    newByte = {q.shIn[6:0], q.syn2[2]};
    stByte = {q.st, q.write_enable_latch, q.busy};
    fnByte = {q.fn, 1'b0};
    canWr = q.write_enable_latch & ~q.busy;
    unique case (q.opc)
      `FPC_OP_STAT_RD: rdByte = stByte;
      `FPC_OP_FUNC_RD: rdByte = fnByte;
      default:         rdByte = q.rp;
    endcase
    // Serial shifter
    if (csHigh) begin
      n.link = fpc_pkg::LS_IDLE;
      n.bitCnt = 6'h00;
      n.outIdx = 3'h0;
      n.soOe = 1'b0;
    end else begin
      n.link = fpc_pkg::LS_BUSY;
      if (sckRise) begin
        n.shIn = newByte;
        if (q.bitCnt != `FPC_BITS_MAX) begin
          n.bitCnt = q.bitCnt + 6'h01;
        end
        if (q.bitCnt[2:0] == 3'h7) begin
          unique case (nb)
            3'h0: n.opc = newByte;
            3'h1: begin
              n.dat = newByte;
              n.addr = {q.addr[15:0], newByte};
            end
            3'h2, 3'h3: n.addr = {q.addr[15:0], newByte};
            default: n.addr = q.addr;
          endcase
        end
      end
      if (sckFall && nb != 3'h0 && isRead(q.opc)) begin
        n.so = rdByte[3'h7 - q.outIdx];
        n.outIdx = q.outIdx + 3'h1;
        n.soOe = 1'b1;
      end
    end
    // Core completion
    if (opDone && q.busy) begin
      n.busy = 1'b0;
      n.write_enable_latch = 1'b0;
    end
    // Commands take effect only at deselect
    if (csRise && nb != 3'h0) begin
      unique case (q.opc)
        `FPC_OP_WR_EN:  n.write_enable_latch = 1'b1;
        `FPC_OP_WR_DIS: n.write_enable_latch = 1'b0;
        `FPC_OP_STAT_WR: begin
          if (canWr && nb >= 3'h2 && !(q.st.lock && wpLow)) begin
            n.st = q.dat[7:2];
            n.write_enable_latch = 1'b0;
          end
        end
        `FPC_OP_FUNC_WR: begin
          if (canWr && nb >= 3'h2) begin
            n.fn.area_top_bottom_sel = q.fn.area_top_bottom_sel | q.dat[1];
            n.fn.irl = q.fn.irl | q.dat[7:4];
            n.write_enable_latch = 1'b0;
          end
        end
        `FPC_OP_RDP_SET: begin
          if (nb >= 3'h2) begin
            n.rp = q.dat;
          end
        end
        `FPC_OP_CHIP_ER0, `FPC_OP_CHIP_ER1: begin
          if (canWr && q.st.lvl == 4'h0) begin
            n.opStart = 1'b1;
            n.op = {fpc_pkg::OP_CHIP, 24'h000000};
            n.busy = 1'b1;
          end
        end
        `FPC_OP_PAGE_PG, `FPC_OP_QUAD_PG, `FPC_OP_SECT_ER,
        `FPC_OP_BLK32_ER, `FPC_OP_BLK_ER: begin
          if (canWr && nb >= 3'h4 &&
              !isProt(q.st.lvl, q.fn.area_top_bottom_sel,
                      q.addr[`FPC_BLK_HI:`FPC_BLK_LO])) begin
            n.opStart = 1'b1;
            n.op.addr = q.addr;
            n.op.kind = (q.opc == `FPC_OP_SECT_ER) ? fpc_pkg::OP_SECT :
                        (q.opc == `FPC_OP_BLK_ER ||
                         q.opc == `FPC_OP_BLK32_ER) ? fpc_pkg::OP_BLK :
                        fpc_pkg::OP_PAGE;
            n.busy = 1'b1;
          end
        end
        `FPC_OP_IROW_PG: begin
          if (canWr && nb >= 3'h4 &&
              !q.fn.irl[q.addr[`FPC_IROW_HI:`FPC_IROW_LO]]) begin
            n.opStart = 1'b1;
            n.op = {fpc_pkg::OP_IROW, q.addr};
            n.busy = 1'b1;
          end
        end
        `FPC_OP_SUSP: begin
          if (q.busy && !q.fn.program_suspended_flag && !q.fn.erase_suspended_flag) begin
            if (q.op.kind == fpc_pkg::OP_PAGE ||
                q.op.kind == fpc_pkg::OP_IROW) begin
              n.fn.program_suspended_flag = 1'b1;
            end else begin
              n.fn.erase_suspended_flag = 1'b1;
            end
          end
        end
        `FPC_OP_RESUME: begin
          n.fn.program_suspended_flag = 1'b0;
          n.fn.erase_suspended_flag = 1'b0;
        end
        default: n.opStart = 1'b0;
      endcase
    end
    // Pin remap and decoded fields
    n.pinsData = n.st.qe;
    n.wpAct = ~n.st.qe & ~q.syn2[1];
    n.holdAct = ~n.st.qe & ~q.syn2[0];
    n.burst = `FPC_BURST_MIN << n.rp[1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.syn1 <= 5'h17;
      q.syn2 <= 5'h17;
      q.csPrev <= 1'b1;
      q.link <= fpc_pkg::LS_IDLE;
      q.st.qe <= `FPC_QE_RST;
      q.pinsData <= `FPC_QE_RST;
      q.rp <= `FPC_RDP_RST;
      q.burst <= `FPC_BURST_MIN;
    end else begin
      q <= n;
    end
  end

  assign so = q.so;
  assign soOe = q.soOe;
  assign opStart = q.opStart;
  assign opReq = q.op;
  assign statusByte = {q.st, q.write_enable_latch, q.busy};
  assign funcByte = {q.fn, 1'b0};
  assign readParam = q.rp;
  assign burstBytes = q.burst;
  assign pinsAsData = q.pinsData;
  assign wpActive = q.wpAct;
  assign holdActive = q.holdAct;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence seqCommit(logic [7:0] code);
    csRise && nb != 3'h0 && q.opc == code;
  endsequence

  sequence seqStatLocked;
    seqCommit(`FPC_OP_STAT_WR) ##0 (q.st.lock && wpLow);
  endsequence

  AST_PROT_INHIBIT: assert property (
    opStart && opReq.kind != fpc_pkg::OP_CHIP &&
    opReq.kind != fpc_pkg::OP_IROW |->
    !isProt($past(q.st.lvl), $past(q.fn.area_top_bottom_sel),
            opReq.addr[`FPC_BLK_HI:`FPC_BLK_LO]))
    else $error("start into protected block");

  AST_CHIP_GATE: assert property (
    opStart && opReq.kind == fpc_pkg::OP_CHIP |-> $past(q.st.lvl) == 4'h0)
    else $error("chip erase with protection set");

  AST_STAT_LOCK: assert property (
    seqStatLocked |=> $stable(q.st))
    else $error("locked status changed");

  AST_STAT_ACCEPT: assert property (
    seqCommit(`FPC_OP_STAT_WR) ##0 (canWr && nb >= 3'h2 &&
    !(q.st.lock && wpLow)) |=> q.st == $past(q.dat[7:2]) && !q.write_enable_latch)
    else $error("status write not taken");

  AST_QUAD_MAP: assert property (
    $changed(q.st.qe) |=> pinsAsData == $past(q.st.qe, 1) ##1 $stable(pinsAsData))
    else $error("pin remap wrong");

  AST_OTP_STICKY: assert property (
    (q.fn.irl & $past(q.fn.irl)) == $past(q.fn.irl) &&
    (q.fn.area_top_bottom_sel || !$past(q.fn.area_top_bottom_sel)))
    else $error("otp bit cleared");

  AST_PROGRAM_SUSPENDED_FLAG_SET: assert property (
    seqCommit(`FPC_OP_SUSP) ##0 (q.busy && !q.fn.erase_suspended_flag && !q.fn.program_suspended_flag &&
    q.op.kind == fpc_pkg::OP_PAGE) |=> q.fn.program_suspended_flag ##1 q.fn.program_suspended_flag)
    else $error("program suspend flag not set");

  AST_ERASE_SUSPENDED_FLAG_SET: assert property (
    seqCommit(`FPC_OP_SUSP) ##0 (q.busy && !q.fn.erase_suspended_flag && !q.fn.program_suspended_flag &&
    q.op.kind != fpc_pkg::OP_PAGE && q.op.kind != fpc_pkg::OP_IROW)
    |=> q.fn.erase_suspended_flag)
    else $error("erase suspend flag not set");

  AST_RESUME: assert property (
    seqCommit(`FPC_OP_RESUME) |=> !q.fn.erase_suspended_flag && !q.fn.program_suspended_flag)
    else $error("resume left flag set");

  AST_ROW_LOCK: assert property (
    opStart && opReq.kind == fpc_pkg::OP_IROW |->
    !$past(q.fn.irl[q.addr[`FPC_IROW_HI:`FPC_IROW_LO]]))
    else $error("locked row programmed");

  AST_RP_LOAD: assert property (
    seqCommit(`FPC_OP_RDP_SET) ##0 nb >= 3'h2 |=> readParam == $past(q.dat)
    ##1 burstBytes == (`FPC_BURST_MIN << readParam[1:0]))
    else $error("read parameters not loaded");

  AST_WEL_CLEAR: assert property (
    opDone && q.busy && !(csRise && q.opc == `FPC_OP_WR_EN) |=> !q.write_enable_latch)
    else $error("write enable not cleared");

  AST_START_NEEDS_WEL: assert property (
    opStart |-> $past(q.write_enable_latch))
    else $error("start without write enable");

  AST_DEFERRED: assert property (
    !csRise |=> $stable(q.st) && $stable(q.fn.area_top_bottom_sel) && $stable(q.fn.irl))
    else $error("setting changed before write end");

  AST_RSV_ZERO: assert property (
    q.opc == `FPC_OP_FUNC_RD && soOe && q.outIdx == 3'h0 |-> !so)
    else $error("reserved bit read as one");

  AST_DESELECT_OE: assert property (
    csHigh |=> !soOe)
    else $error("output enabled while deselected");

  AST_BURST_LEN: assert property (
    readParam[1:0] == 2'h3 |-> burstBytes == 7'h40)
    else $error("longest burst length wrong");

  AST_HOLD_MAP: assert property (
    holdActive |-> !pinsAsData)
    else $error("hold active in quad mode");
endmodule

// file: logic/fpc_cfg.svh
// Opcodes, field positions and reset values of the protect registers
// Assumes inclusion by bare name from the design file
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
`define FPC_OP_WR_EN    8'h06
`define FPC_OP_WR_DIS   8'h04
`define FPC_OP_STAT_WR  8'h01
`define FPC_OP_FUNC_WR  8'h42
`define FPC_OP_RDP_SET  8'hC0
`define FPC_OP_STAT_RD  8'h05
`define FPC_OP_FUNC_RD  8'h48
`define FPC_OP_RDP_RD   8'h61
`define FPC_OP_CHIP_ER0 8'hC7
`define FPC_OP_CHIP_ER1 8'h60
`define FPC_OP_PAGE_PG  8'h02
`define FPC_OP_QUAD_PG  8'h32
`define FPC_OP_SECT_ER  8'h20
`define FPC_OP_BLK32_ER 8'h52
`define FPC_OP_BLK_ER   8'hD8
`define FPC_OP_IROW_PG  8'h62
`define FPC_OP_SUSP     8'h75
`define FPC_OP_RESUME   8'h7A
`define FPC_RDP_RST     8'hE0
`define FPC_QE_RST      1'b0
`define FPC_BLK_HI      22
`define FPC_BLK_LO      16
`define FPC_IROW_HI     9
`define FPC_IROW_LO     8
`define FPC_BITS_MAX    6'h28
`define FPC_BURST_MIN   7'h08
`define FPC_ALL_BLKS    8'h80
`endif

// file: logic/fpc_pkg.sv
// Types of the protect and configuration register block
// Assumes nothing of its surroundings
package fpc_pkg;
  typedef enum logic [1:0] {
    LS_IDLE = 2'b01,
    LS_BUSY = 2'b10
  } fpc_link_e;
  typedef enum logic [2:0] {
    OP_PAGE = 3'h0,
    OP_SECT = 3'h1,
    OP_BLK  = 3'h2,
    OP_CHIP = 3'h3,
    OP_IROW = 3'h4
  } fpc_op_e;
  typedef struct packed {
    fpc_op_e     kind;
    logic [23:0] addr;
  } fpc_op_s;
  typedef struct packed {
    logic       lock;
    logic       qe;
    logic [3:0] lvl;
  } fpc_stat_s;
  typedef struct packed {
    logic [3:0] irl;
    logic       erase_suspended_flag;
    logic       program_suspended_flag;
    logic       area_top_bottom_sel;
  } fpc_func_s;
  typedef struct packed {
    logic [4:0]  syn1;
    logic [4:0]  syn2;
    logic        sckPrev;
    logic        csPrev;
    fpc_link_e   link;
    logic [5:0]  bitCnt;
    logic [7:0]  shIn;
    logic [7:0]  opc;
    logic [7:0]  dat;
    logic [23:0] addr;
    logic [2:0]  outIdx;
    logic        so;
    logic        soOe;
    fpc_stat_s   st;
    logic        write_enable_latch;
    logic        busy;
    fpc_func_s   fn;
    logic [7:0]  rp;
    logic        opStart;
    fpc_op_s     op;
    logic        pinsData;
    logic        wpAct;
    logic        holdAct;
    logic [6:0]  burst;
  } fpc_state_s;
endpackage

// file: dv/fpc_host_model.sv
// Host side of the serial link: mode 0 frames on csN, sck and si
// Assumes the bench calls xfer; sck period is eight clk cycles
module fpc_host_model (
  input  wire logic clk,
  input  wire logic so,
  output logic      csN,
  output logic      sck,
  output logic      si
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One frame: opcode, nb argument bytes, then nr bits read back
  task automatic xfer(input  logic [7:0]  op,
                      input  logic [23:0] arg,
                      input  int          nb,
                      input  int          nr,
                      output logic [15:0] rd);
    logic [47:0] sh;
    int          n;
    sh = {op, arg, 16'h0000};
    n  = 8 + 8 * nb + nr;
    rd = 16'h0000;
    @(posedge clk) csN <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si <= sh[47-i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      if (i >= n - nr) begin
        rd = {rd[14:0], so};
      end
      repeat (2) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    csN <= 1'b1;
    si  <= ~si;
    repeat (10) @(posedge clk);
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench of the protect and configuration registers
// Assumes fpc_pkg compiled first; bench acts as host and array core
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk, arst_n, csN, sck, si, wpN, holdN, opDone;
  logic             so, soOe, opStart, pinsAsData, wpActive, holdActive;
  fpc_pkg::fpc_op_s opReq, eo;
  fpc_pkg::fpc_op_s lastOp = '0;
  logic [7:0]       statusByte, funcByte, readParam;
  logic [6:0]       burstBytes;
  logic [15:0]      rdv;
  int               mismatches, cmpCount, en;
  int               nStart = 0;

  fpc_regs DUT (.clk(clk), .arst_n(arst_n), .csN(csN), .sck(sck),
    .si(si), .wpN(wpN), .holdN(holdN), .opDone(opDone), .so(so),
    .soOe(soOe), .opStart(opStart), .opReq(opReq),
    .statusByte(statusByte), .funcByte(funcByte), .readParam(readParam),
    .burstBytes(burstBytes), .pinsAsData(pinsAsData),
    .wpActive(wpActive), .holdActive(holdActive));

  fpc_host_model host (.clk(clk), .so(so), .csN(csN), .sck(sck), .si(si));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (opStart === 1'b1) begin
      nStart <= nStart + 1;
      lastOp <= opReq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic cmd(input logic [7:0] op, input logic [23:0] arg,
                     input int nb);
    host.xfer(op, arg, nb, 0, rdv);
  endtask

  task automatic write_enable_cmd();
    cmd(8'h06, 24'h000000, 0);
  endtask

  task automatic stw(input logic [7:0] d);
    cmd(8'h01, {d, 16'h0000}, 1);
  endtask

  task automatic done();
    @(posedge clk) opDone <= 1'b1;
    @(posedge clk) opDone <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chkOp(input int n, input fpc_pkg::fpc_op_s e);
    cmpCount++;
    if (nStart != n || lastOp !== e) begin
      mismatches++;
      $display("[ERR] opReq exp %0d %h got %0d %h", n, e, nStart, lastOp);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && cmpCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    arst_n = 1'b0;
    wpN    = 1'b1;
    holdN  = 1'b1;
    opDone = 1'b0;
    en     = 0;
    eo     = '0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("readParam", 8'hE0, readParam);
    chk("burst", 8'h08, {1'b0, burstBytes});
    chk("func", 8'h00, funcByte);
    for (int k = 0; k < 4; k++) begin
      cmd(8'hC0, {3'h5, 2'h2, 1'b1, k[1:0], 16'h0000}, 1);
      chk("readParam", {3'h5, 2'h2, 1'b1, k[1:0]}, readParam);
      chk("burst", 8'h08 << k, {1'b0, burstBytes});
    end
    host.xfer(8'h61, 24'h000000, 0, 8, rdv);
    chk("rdParam", 8'hB7, rdv[7:0]);
    stw(8'h04);
    chk("status", 8'h00, statusByte);
    write_enable_cmd();
    chk("status", 8'h02, statusByte);
    stw(8'h04);
    chk("status", 8'h04, statusByte);
    host.xfer(8'h05, 24'h000000, 0, 16, rdv);
    chk("rd0", 8'h04, rdv[15:8]);
    chk("rd1", 8'h04, rdv[7:0]);
    write_enable_cmd();
    cmd(8'h02, 24'h7F0000, 3);
    chk("status", 8'h06, statusByte);
    chkOp(en, eo);
    cmd(8'h02, 24'h7E0000, 3);
    en = 1;
    eo = {fpc_pkg::OP_PAGE, 24'h7E0000};
    chkOp(en, eo);
    chk("status", 8'h07, statusByte);
    cmd(8'h75, 24'h000000, 0);
    chk("func", 8'h04, funcByte);
    cmd(8'h7A, 24'h000000, 0);
    chk("func", 8'h00, funcByte);
    done();
    chk("status", 8'h04, statusByte);
    write_enable_cmd();
    cmd(8'hC7, 24'h000000, 0);
    chk("status", 8'h06, statusByte);
    cmd(8'h20, 24'h000000, 3);
    en = 2;
    eo = {fpc_pkg::OP_SECT, 24'h000000};
    chkOp(en, eo);
    cmd(8'h75, 24'h000000, 0);
    chk("func", 8'h08, funcByte);
    cmd(8'h7A, 24'h000000, 0);
    chk("func", 8'h00, funcByte);
    done();
    write_enable_cmd();
    stw(8'h84);
    chk("status", 8'h84, statusByte);
    wpN <= 1'b0;
    repeat (6) @(posedge clk);
    chk("wpActive", 8'h01, {7'h00, wpActive});
    write_enable_cmd();
    stw(8'h00);
    chk("status", 8'h86, statusByte);
    wpN <= 1'b1;
    stw(8'h20);
    chk("status", 8'h20, statusByte);
    write_enable_cmd();
    cmd(8'h02, 24'h000000, 3);
    chk("status", 8'h22, statusByte);
    chkOp(en, eo);
    stw(8'h40);
    chk("quad", 8'h41, {statusByte[7:1], pinsAsData});
    wpN <= 1'b0;
    repeat (6) @(posedge clk);
    chk("wpActive", 8'h00, {7'h00, wpActive});
    wpN <= 1'b1;
    write_enable_cmd();
    cmd(8'h42, 24'h130000, 1);
    chk("func", 8'h12, funcByte);
    write_enable_cmd();
    cmd(8'h42, 24'h000000, 1);
    chk("func", 8'h12, funcByte);
    host.xfer(8'h48, 24'h000000, 0, 16, rdv);
    chk("rdFunc0", 8'h12, rdv[15:8]);
    chk("rdFunc1", 8'h12, rdv[7:0]);
    write_enable_cmd();
    stw(8'h04);
    chk("quad", 8'h04, {statusByte[7:1], pinsAsData});
    write_enable_cmd();
    cmd(8'h02, 24'h000000, 3);
    chkOp(en, eo);
    cmd(8'h02, 24'h010000, 3);
    en = 3;
    eo = {fpc_pkg::OP_PAGE, 24'h010000};
    chkOp(en, eo);
    done();
    write_enable_cmd();
    stw(8'h00);
    write_enable_cmd();
    cmd(8'h62, 24'h000000, 3);
    chkOp(en, eo);
    cmd(8'h62, 24'h000100, 3);
    en = 4;
    eo = {fpc_pkg::OP_IROW, 24'h000100};
    chkOp(en, eo);
    done();
    chk("status", 8'h00, statusByte);
    end_of_test();
  end
endmodule
